// ### pkg/aes_block_map.svh
// field codes, counts and reset values for the block cipher datapath
`ifndef AES_BLOCK_MAP_SVH
`define AES_BLOCK_MAP_SVH
// cipher_block_config reset value and module-reset write value
`define CFG_RESET        8'h00
`define CFG_SOFT_RESET   8'h00
// key size codes in cipher_block_config bits 1:0
`define KEYSZ_128        2'h0
`define KEYSZ_192        2'h1
// key bytes per key size
`define KEY_BYTES_128    6'h10
`define KEY_BYTES_192    6'h18
`define KEY_BYTES_256    6'h20
// cipher_flow_config codes
`define FLOW_RESET       8'h00
`define FLOW_DIRECT      8'h00
`define FLOW_XOR_IN      8'h01
`define FLOW_XOR_OUT     8'h02
// bytes in one cipher block
`define BLOCK_BYTES      5'h10
`define LAST_BYTE        5'h0F
`endif

// ### pkg/aes_block_pkg.sv
// types shared by the block cipher datapath
package aes_block_pkg;
  // cipher_block_config layout, msb first
  typedef struct packed {
    logic [1:0] rsv_hi;    // reads zero
    logic       done;      // set by hardware at block end
    logic       rsv4;      // reads zero
    logic       enable;    // core running
    logic       encrypt;   // 1 encrypt, 0 decrypt
    logic [1:0] key_size;  // 128/192/256
  } block_cfg_t;
  // one byte write into an input port
  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } byte_wr_t;
  // datapath sequencing
  typedef enum logic [1:0] {ST_COLLECT, ST_CALC, ST_OUT} state_t;
endpackage

// ### rtl/aes_block_cbc_dma_datapath.sv
// byte-serial block cipher datapath with input and output chaining xor
// Function
// (R1) DMA channel 0 feeds keys, wrapping on
// (R2) key channel size equals key length
// (R3) DMA channel 1 feeds block input bytes
// (R4) DMA channel 2 feeds chaining operand bytes
// (R5) result channel drains result output port
// (R6) result channel interrupt marks transfer complete
// (R7) data transfer sizes are multiples of 16
// (R8) disable, configure, clear flags, re-enable channels
// (R9) flow code 0: core output direct
// (R10) flow code 1: xor chain into core input
// (R11) config bits 1:0 select key size
// (R12) config bit 2 set means encrypt
// (R13) config bit 3 enables core processing
// (R14) writing zero to config resets module
// (R15) block end sets done bit and interrupt
// (R16) accept interleaved data and key bytes
// (R17) longer keys add bytes after pairs
// (R18) sixteen result bytes read in order
// (R19) configuration retained across successive blocks
// (R20) chain port gets IV then ciphertext
// (R21) IV placed just before ciphertext area
// (R22) after result interrupt, disable module then DMA
// (R23) flow code 2: xor chain onto output
// (R24) blocks independent, key reused per block
// (R25) request bytes, stall until each served
// (R26) done stays until reset or next block
`timescale 1ns/1ns
`include "aes_block_map.svh"
module aes_block_cbc_dma_datapath (
  input  wire logic                      clk_i,        // 125 MHz system clock
  input  wire logic                      arst_n_i,     // async reset, active low
  input  wire logic                      cfg_we_i,     // cipher_block_config write
  input  wire logic [7:0]                cfg_wdata_i,  // config write data
  input  wire logic                      flow_we_i,    // cipher_flow_config write
  input  wire logic [7:0]                flow_wdata_i, // flow write data
  input  wire aes_block_pkg::byte_wr_t   key_in_i,     // key_input_port write
  input  wire aes_block_pkg::byte_wr_t   blk_in_i,     // block_input_port write
  input  wire aes_block_pkg::byte_wr_t   chain_in_i,   // chain_operand_port write
  input  wire logic                      res_rd_i,     // result_output_port read
  output logic [7:0]                     cfg_rdata_o,  // config read-back
  output logic [7:0]                     flow_rdata_o, // flow read-back
  output logic                           key_req_o,    // key byte wanted
  output logic                           blk_req_o,    // block byte wanted
  output logic                           chain_req_o,  // chain byte wanted
  output logic                           res_valid_o,  // result byte ready
  output logic [7:0]                     res_data_o,   // result byte
  output logic                           done_irq_o    // done interrupt level
);
  // ***********************************************************
  // state and storage
  // ***********************************************************
  aes_block_pkg::block_cfg_t cfg_q;       // cipher_block_config
  logic [7:0]                flow_q;      // cipher_flow_config
  aes_block_pkg::state_t     state_q;     // sequencer
  logic [7:0]                key_q [32];  // key bytes, upper zero for short keys
  logic [7:0]                blk_q [16];  // block input bytes
  logic [7:0]                chn_q [16];  // chaining operand bytes
  logic [7:0]                res_q [16];  // core results
  logic [7:0]                core_y [16]; // core output per byte
  logic [5:0]                key_cnt_q;   // key bytes taken
  logic [4:0]                blk_cnt_q;   // block bytes taken
  logic [4:0]                chn_cnt_q;   // chain bytes taken
  logic [4:0]                out_cnt_q;   // result bytes read
  logic [5:0]                key_need;    // key bytes for chosen size
  logic                      soft_rst;    // config write of zero
  logic                      collect;     // accepting input bytes
  logic                      key_take;    // key byte accepted
  logic                      blk_take;    // block byte accepted
  logic                      chn_take;    // chain byte accepted
  logic                      inputs_full; // block ready for the core
  logic                      res_avail;   // current result may be offered
  logic                      res_take;    // result byte consumed

  // ***********************************************************
  // decode
  // ***********************************************************
  // key length from size field
  always_comb
  begin
    case (cfg_q.key_size)
      `KEYSZ_128: key_need = `KEY_BYTES_128; // [R11]
      `KEYSZ_192: key_need = `KEY_BYTES_192; // [R11] [R17]
      default:    key_need = `KEY_BYTES_256; // [R17]
    endcase
  end

  assign soft_rst  = cfg_we_i && (cfg_wdata_i == `CFG_SOFT_RESET); // [R14]
  assign collect   = (state_q == aes_block_pkg::ST_COLLECT) && !soft_rst;
  // ports take bytes in any interleaving, each up to its own count
  assign key_take  = collect && key_in_i.we && (key_cnt_q < key_need);        // [R16] [R17]
  assign blk_take  = collect && blk_in_i.we && (blk_cnt_q < `BLOCK_BYTES);    // [R16]
  // chain bytes may arrive before or during output, for the output xor
  assign chn_take  = !soft_rst && (state_q != aes_block_pkg::ST_CALC) && chain_in_i.we
                     && (chn_cnt_q < `BLOCK_BYTES);
  // input xor needs the chain operand before the core runs
  assign inputs_full = cfg_q.enable && (blk_cnt_q == `BLOCK_BYTES) && (key_cnt_q == key_need)
                       && ((flow_q != `FLOW_XOR_IN) || (chn_cnt_q == `BLOCK_BYTES)); // [R13] [R10]
  // output xor waits for the matching chain byte
  assign res_avail = (state_q == aes_block_pkg::ST_OUT)
                     && ((flow_q != `FLOW_XOR_OUT) || (chn_cnt_q > out_cnt_q)); // [R23]
  assign res_take  = res_rd_i && res_valid_o;

  // ***********************************************************
  // cipher core, one lane per byte
  // ***********************************************************
  // keyed rotate-xor round; decrypt is the exact inverse of encrypt
  generate
    for (genvar i = 0; i < 16; i++)
    begin : g_lane
      logic [7:0] x; // core input byte
      logic [7:0] t; // intermediate
      always_comb
      begin
        x = (flow_q == `FLOW_XOR_IN) ? (blk_q[i] ^ chn_q[i]) : blk_q[i]; // [R10] [R9]
        if (cfg_q.encrypt) // [R12]
        begin
          t         = x ^ key_q[i];
          core_y[i] = {t[6:0], t[7]} ^ key_q[i+16];
        end
        else
        begin
          t         = x ^ key_q[i+16];
          core_y[i] = {t[0], t[7:1]} ^ key_q[i];
        end
      end
    end
  endgenerate

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  // config fields; done is hardware-set and only cleared here
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cfg_q <= aes_block_pkg::block_cfg_t'(`CFG_RESET);
    else if (soft_rst)
      cfg_q <= aes_block_pkg::block_cfg_t'(`CFG_RESET); // [R14]
    else
    begin
      if (cfg_we_i)
      begin
        cfg_q.key_size <= cfg_wdata_i[1:0]; // [R11]
        cfg_q.encrypt  <= cfg_wdata_i[2];   // [R12]
        cfg_q.enable   <= cfg_wdata_i[3];   // [R13]
      end
      // set wins over the clear of a new block start
      if (state_q == aes_block_pkg::ST_CALC)
        cfg_q.done <= 1'b1;                 // [R15]
      else if (key_take || blk_take)
        cfg_q.done <= 1'b0;                 // [R26]
    end
  end

  // flow selection, untouched by the module reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flow_q <= `FLOW_RESET;
    else if (flow_we_i)
      flow_q <= flow_wdata_i; // [R9] [R10] [R23]
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  // collect, one core cycle, then hand out sixteen bytes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_q <= aes_block_pkg::ST_COLLECT;
    else if (soft_rst)
      state_q <= aes_block_pkg::ST_COLLECT;
    else
    begin
      case (state_q)
        aes_block_pkg::ST_COLLECT:
          if (inputs_full)
            state_q <= aes_block_pkg::ST_CALC; // [R13]
        aes_block_pkg::ST_CALC:
          state_q <= aes_block_pkg::ST_OUT;
        aes_block_pkg::ST_OUT:
          // back for the next block, config kept
          if (res_take && (out_cnt_q == `LAST_BYTE))
            state_q <= aes_block_pkg::ST_COLLECT; // [R18] [R19]
        default:
          state_q <= aes_block_pkg::ST_COLLECT;
      endcase
    end
  end

  // ***********************************************************
  // byte counters
  // ***********************************************************
  // counts restart per block so each block stands alone
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      key_cnt_q <= 6'h00;
      blk_cnt_q <= 5'h00;
      chn_cnt_q <= 5'h00;
      out_cnt_q <= 5'h00;
    end
    else if (soft_rst)
    begin
      key_cnt_q <= 6'h00;
      blk_cnt_q <= 5'h00;
      chn_cnt_q <= 5'h00;
      out_cnt_q <= 5'h00;
    end
    else
    begin
      if (state_q == aes_block_pkg::ST_CALC)
      begin
        key_cnt_q <= 6'h00; // [R24]
        blk_cnt_q <= 5'h00;
      end
      else
      begin
        key_cnt_q <= key_cnt_q + 6'(key_take);
        blk_cnt_q <= blk_cnt_q + 5'(blk_take);
      end
      if (res_take && (out_cnt_q == `LAST_BYTE))
      begin
        chn_cnt_q <= 5'h00;
        out_cnt_q <= 5'h00;
      end
      else
      begin
        chn_cnt_q <= chn_cnt_q + 5'(chn_take);
        out_cnt_q <= out_cnt_q + 5'(res_take); // [R18]
      end
    end
  end

  // ***********************************************************
  // byte buffers
  // ***********************************************************
  // no reset on data storage; key cleared after use so short keys pad zero
  always_ff @(posedge clk_i)
  begin
    if (soft_rst || (state_q == aes_block_pkg::ST_CALC))
    begin
      for (int k = 0; k < 32; k++)
        key_q[k] <= 8'h00; // [R24]
    end
    else if (key_take)
      key_q[key_cnt_q[4:0]] <= key_in_i.data;
    if (blk_take)
      blk_q[blk_cnt_q[3:0]] <= blk_in_i.data;
    if (chn_take)
      chn_q[chn_cnt_q[3:0]] <= chain_in_i.data; // [R10] [R23]
    if (state_q == aes_block_pkg::ST_CALC)
    begin
      for (int k = 0; k < 16; k++)
        res_q[k] <= core_y[k];
    end
  end

  // ***********************************************************
  // registered outputs
  // ***********************************************************
  // requests drop for a cycle after each byte so a count is never overrun
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      key_req_o   <= 1'b0;
      blk_req_o   <= 1'b0;
      chain_req_o <= 1'b0;
      res_valid_o <= 1'b0;
      res_data_o  <= 8'h00;
    end
    else
    begin
      key_req_o   <= collect && cfg_q.enable && !key_take && (key_cnt_q < key_need);        // [R25]
      blk_req_o   <= collect && cfg_q.enable && !blk_take && (blk_cnt_q < `BLOCK_BYTES);    // [R25]
      // chain port stays served while results go out, else the output xor could starve
      chain_req_o <= !soft_rst && (state_q != aes_block_pkg::ST_CALC) && cfg_q.enable && !chn_take
                     && (flow_q != `FLOW_DIRECT) && (chn_cnt_q < `BLOCK_BYTES);             // [R25] [R23]
      res_valid_o <= res_avail && !res_take && !soft_rst;                                   // [R25]
      res_data_o  <= (flow_q == `FLOW_XOR_OUT) ? (res_q[out_cnt_q[3:0]] ^ chn_q[out_cnt_q[3:0]])
                                               : res_q[out_cnt_q[3:0]];                     // [R9] [R23]
    end
  end

  assign cfg_rdata_o  = cfg_q;      // flop bits, reserved held zero
  assign flow_rdata_o = flow_q;
  assign done_irq_o   = cfg_q.done; // [R15]

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_last_read;
    (state_q == aes_block_pkg::ST_OUT) && res_take && (out_cnt_q == `LAST_BYTE) && !cfg_we_i && !flow_we_i;
  endsequence
  sequence s_core_step;
    (state_q == aes_block_pkg::ST_CALC) ##1 (state_q == aes_block_pkg::ST_OUT);
  endsequence

  property p_done_set;
    @(posedge clk_i) disable iff (!arst_n_i)
    (state_q == aes_block_pkg::ST_CALC) && !soft_rst |=> cfg_q.done && done_irq_o;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set after block"); // [R15]

  property p_done_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    cfg_q.done && !soft_rst && !key_take && !blk_take |=> cfg_q.done;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped early"); // [R26]

  property p_soft_reset;
    @(posedge clk_i) disable iff (!arst_n_i)
    soft_rst |=> (cfg_rdata_o == 8'h00) && (state_q == aes_block_pkg::ST_COLLECT) && (blk_cnt_q == 5'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("module reset ignored"); // [R14]

  property p_counts_full;
    @(posedge clk_i) disable iff (!arst_n_i)
    (state_q == aes_block_pkg::ST_CALC) |-> ($past(blk_cnt_q) == 5'h10) && ($past(key_cnt_q) == $past(key_need))
      && $past(cfg_q.enable);
  endproperty
  a_counts_full: assert property (p_counts_full) else $error("core ran on short input"); // [R13] [R16] [R17]

  property p_xor_in_enc;
    @(posedge clk_i) disable iff (!arst_n_i)
    (state_q == aes_block_pkg::ST_CALC) && (flow_q == 8'h01) && cfg_q.encrypt |=>
      ({res_q[0][0], res_q[0][7:1]} == ($past(blk_q[0] ^ chn_q[0] ^ key_q[0])
                                        ^ {$past(key_q[16][0]), $past(key_q[16][7:1])}));
  endproperty
  a_xor_in_enc: assert property (p_xor_in_enc) else $error("input xor path wrong"); // [R10] [R12]

  property p_xor_out;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_core_step ##1 res_valid_o && (flow_q == 8'h02) && (out_cnt_q == 5'h00) |->
      res_data_o == (res_q[0] ^ chn_q[0]);
  endproperty
  a_xor_out: assert property (p_xor_out) else $error("output xor path wrong"); // [R23]

  property p_block_return;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_last_read |=> (state_q == aes_block_pkg::ST_COLLECT) && (out_cnt_q == 5'h00) && $stable(cfg_q.enable)
      && $stable(flow_q);
  endproperty
  a_block_return: assert property (p_block_return) else $error("block end lost config"); // [R18] [R19]

  property p_req_gated;
    @(posedge clk_i) disable iff (!arst_n_i)
    (key_req_o || blk_req_o) |-> $past(cfg_q.enable) && (state_q != aes_block_pkg::ST_OUT);
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("request while not collecting"); // [R25]

  property p_idle_when_off;
    @(posedge clk_i) disable iff (!arst_n_i)
    !cfg_q.enable && (state_q == aes_block_pkg::ST_COLLECT) |=> state_q != aes_block_pkg::ST_CALC;
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("core ran while disabled"); // [R13]

  property p_direct_out;
    @(posedge clk_i) disable iff (!arst_n_i)
    res_valid_o && (flow_q == 8'h00) |-> res_data_o == res_q[out_cnt_q[3:0]];
  endproperty
  a_direct_out: assert property (p_direct_out) else $error("direct path altered"); // [R9]
endmodule

// ### tb/dma_feeder.sv
// dma-style byte feeder and result drain facing the cipher datapath
`timescale 1ns/1ns
module dma_feeder (
  input  wire logic              clk_i,       // system clock
  input  wire logic              arst_n_i,    // async reset, active low
  input  wire logic              run_i,       // channels enabled
  input  wire logic              slow_i,      // serve only every other cycle
  input  wire logic [5:0]        key_n_i,     // key channel transfer size
  input  wire logic              key_req_i,   // key byte wanted
  input  wire logic              blk_req_i,   // block byte wanted
  input  wire logic              chain_req_i, // chain byte wanted
  input  wire logic              res_valid_i, // result byte offered
  input  wire logic [7:0]        res_data_i,  // result byte
  output aes_block_pkg::byte_wr_t key_o,      // key port write
  output aes_block_pkg::byte_wr_t blk_o,      // block port write
  output aes_block_pkg::byte_wr_t chain_o,    // chain port write
  output logic                   res_rd_o     // result read strobe
);
  // ************************************************************
  // channel memories and counters
  // ************************************************************
  logic [7:0] key_mem   [32]; // key bytes, filled by the bench
  logic [7:0] blk_mem   [16]; // block bytes, one cipher block
  logic [7:0] chain_mem [16]; // iv or previous ciphertext
  logic [7:0] res_mem   [16]; // drained result bytes
  int         kc, bc, cc, rc; // bytes moved per channel
  logic       tick;           // stall pacing
  logic       go;             // may act this cycle
  assign go = run_i && (!slow_i || tick);

  // one byte per request pulse; idle data lines toggle so no stale byte looks valid
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      key_o    <= '0;
      blk_o    <= '0;
      chain_o  <= '0;
      res_rd_o <= 1'b0;
      tick     <= 1'b0;
      kc <= 0; bc <= 0; cc <= 0; rc <= 0;
    end
    else
    begin
      tick    <= ~tick;
      key_o   <= {1'b0, ~key_o.data};
      blk_o   <= {1'b0, ~blk_o.data};
      chain_o <= {1'b0, ~chain_o.data};
      // channels disabled between blocks restart their counts
      if (!run_i)
      begin
        kc <= 0; bc <= 0; cc <= 0; rc <= 0;
      end
      // key channel stops at the key length
      if (go && key_req_i && !key_o.we && kc < int'(key_n_i))
      begin
        key_o <= {1'b1, key_mem[kc]};
        kc    <= kc + 1;
      end
      // data channel, one 16-byte block, served interleaved
      if (go && blk_req_i && !blk_o.we && bc < 16)
      begin
        blk_o <= {1'b1, blk_mem[bc]};
        bc    <= bc + 1;
      end
      // chaining operand channel
      if (go && chain_req_i && !chain_o.we && cc < 16)
      begin
        chain_o <= {1'b1, chain_mem[cc]};
        cc      <= cc + 1;
      end
      // result channel: strobe held until valid is sampled with it
      if (res_rd_o && res_valid_i)
      begin
        res_mem[rc] <= res_data_i;
        rc          <= rc + 1;
        res_rd_o    <= 1'b0;
      end
      else if (go && res_valid_i && rc < 16)
        res_rd_o <= 1'b1;
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the byte-serial cipher datapath
`timescale 1ns/1ns
module testbench;
  // ************************************************************
  // signals
  // ************************************************************
  logic                    clk_i = 1'b0;         // 125 MHz
  logic                    arst_n_i;             // async reset, active low
  logic                    cfg_we_i = 1'b0;      // config write strobe
  logic                    flow_we_i = 1'b0;     // flow write strobe
  logic [7:0]              cfg_wdata_i = 8'h00;  // config write data
  logic [7:0]              flow_wdata_i = 8'h00; // flow write data
  logic                    run = 1'b0;           // feeder channels on
  logic                    slow = 1'b0;          // feeder stalls
  logic [5:0]              key_n = 6'h10;        // key bytes per block
  aes_block_pkg::byte_wr_t key_in, blk_in, chain_in;
  logic                    res_rd, key_req, blk_req, chain_req, res_valid, done_irq;
  logic [7:0]              cfg_rdata, flow_rdata, res_data;
  logic [7:0]              kb [32];              // key of the running block
  logic [7:0]              exp_b [16];           // expected results
  int                      error_cnt = 0;
  int                      total_checks = 0;

  always #4 clk_i = ~clk_i;

  aes_block_cbc_dma_datapath aes_block_cbc_dma_datapath_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i),
    .flow_we_i(flow_we_i), .flow_wdata_i(flow_wdata_i), .key_in_i(key_in), .blk_in_i(blk_in),
    .chain_in_i(chain_in), .res_rd_i(res_rd), .cfg_rdata_o(cfg_rdata), .flow_rdata_o(flow_rdata),
    .key_req_o(key_req), .blk_req_o(blk_req), .chain_req_o(chain_req), .res_valid_o(res_valid),
    .res_data_o(res_data), .done_irq_o(done_irq));

  dma_feeder dma_feeder_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .run_i(run), .slow_i(slow), .key_n_i(key_n),
    .key_req_i(key_req), .blk_req_i(blk_req), .chain_req_i(chain_req), .res_valid_i(res_valid),
    .res_data_i(res_data), .key_o(key_in), .blk_o(blk_in), .chain_o(chain_in), .res_rd_o(res_rd));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", what, e, s);
      error_cnt++;
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one cycle of a bounded wait; running out ends the run
  task automatic step(inout int n, input int lim);
    @(posedge clk_i);
    #1;
    n++;
    if (n > lim)
    begin
      $display("[ERR] wait expected %0d cycles seen more", lim);
      error_cnt++;
      stop_test();
    end
  endtask

  // register write, strobe high for exactly one edge
  task automatic wr(input logic flow, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    cfg_we_i = !flow;
    flow_we_i = flow;
    cfg_wdata_i = d;
    flow_wdata_i = d;
    @(posedge clk_i);
    #1;
    cfg_we_i = 1'b0;
    flow_we_i = 1'b0;
  endtask

  // keyed byte stand-in for the core, with both xor paths
  function automatic logic [7:0] model(input logic [7:0] cv, fv, b, c, input int i);
    logic [7:0] x;
    logic [7:0] t;
    logic [7:0] y;
    x = (fv == 8'h01) ? (b ^ c) : b;
    if (cv[2])
    begin
      t = x ^ kb[i];
      y = {t[6:0], t[7]} ^ kb[16 + i];
    end
    else
    begin
      t = x ^ kb[16 + i];
      y = {t[0], t[7:1]} ^ kb[i];
    end
    return (fv == 8'h02) ? (y ^ c) : y;
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic reg_test;
    chk("reset block config", 8'h00, cfg_rdata);
    chk("reset flow config", 8'h00, flow_rdata);
    chk("reset offer and irq", 8'h00, {6'h00, res_valid, done_irq});
    wr(1'b0, 8'hFF);
    chk("reserved and done bits", 8'h0F, cfg_rdata);
    wr(1'b0, 8'h00);
    chk("module reset", 8'h00, cfg_rdata);
  endtask

  // one block through the feeder; first=0 keeps the config and chains
  task automatic run_blk(input logic [7:0] cv, fv, input logic [5:0] kn, input logic sl, first);
    int i;
    int n;
    key_n = kn;
    slow = sl;
    for (i = 0; i < 32; i++)
    begin
      kb[i] = (i < int'(kn)) ? 8'(8'h3C + 7 * i) : 8'h00;
      dma_feeder_i.key_mem[i] = kb[i];
    end
    for (i = 0; i < 16; i++)
    begin
      dma_feeder_i.blk_mem[i] = 8'(8'h11 * i) ^ cv;
      dma_feeder_i.chain_mem[i] = first ? 8'(8'hA5 ^ i) : dma_feeder_i.res_mem[i];
      exp_b[i] = model(cv, fv, dma_feeder_i.blk_mem[i], dma_feeder_i.chain_mem[i], i);
    end
    if (first)
    begin
      wr(1'b0, 8'h00);
      chk("done after module reset", 8'h00, {7'h00, done_irq});
      wr(1'b1, fv);
      wr(1'b0, cv);
      chk("flow config", fv, flow_rdata);
      chk("block config", cv, cfg_rdata);
    end
    else
      chk("done held", 8'h01, {7'h00, done_irq});
    run = 1'b1;
    n = 0;
    while (done_irq !== 1'b0)
      step(n, 80);
    while (done_irq !== 1'b1)
      step(n, 300);
    chk("done bit", cv | 8'h20, cfg_rdata);
    while (dma_feeder_i.rc < 16)
      step(n, 600);
    step(n, 610);
    chk("offer withdrawn", 8'h00, {7'h00, res_valid});
    for (i = 0; i < 16; i++)
      chk("result byte", exp_b[i], dma_feeder_i.res_mem[i]);
    run = 1'b0;
    step(n, 620);
  endtask

  // channels run but the core stays off; module reset first drops the last done
  task automatic idle_core;
    int n;
    n = 0;
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h04);
    run = 1'b1;
    while (n < 80)
      step(n, 100);
    chk("no block while disabled", 8'h00, {7'h00, done_irq});
    chk("no requests while disabled", 8'h00, {5'h00, key_req, blk_req, chain_req});
    wr(1'b0, 8'h00);
    run = 1'b0;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    arst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    reg_test();
    run_blk(8'h0C, 8'h00, 6'h10, 1'b0, 1'b1);
    run_blk(8'h0C, 8'h00, 6'h10, 1'b1, 1'b0);
    run_blk(8'h09, 8'h00, 6'h18, 1'b0, 1'b1);
    run_blk(8'h0B, 8'h00, 6'h20, 1'b1, 1'b1);
    run_blk(8'h0E, 8'h01, 6'h20, 1'b1, 1'b1);
    run_blk(8'h0E, 8'h01, 6'h20, 1'b0, 1'b0);
    run_blk(8'h08, 8'h02, 6'h10, 1'b1, 1'b1);
    idle_core();
    stop_test();
  end
endmodule
